// [rtl/token_bus_status_flags.sv]
// Status flags of the token-bus network core with their APB register access.
//
// How it works
// RL1 - Receiver inhibited flag sets when a packet lands; reads high until first enable.
// RL2 - Only a receive-enable command clears receiver inhibited; nothing is received meanwhile.
// RL3 - Interrupt while receiver inhibited is high and its mask bit is set.
// RL4 - While receiver inhibited, packets addressed to this node are answered with NAK.
// RL5 - Status bits 6 and 5 are reserved and carry no meaning.
// RL6 - Reset occurred flag sets on hardware reset, software reset or node id zero write.
// RL7 - Only the clear-flags command clears the reset occurred flag.
// RL8 - Test bit 3 reads zero in normal operation.
// RL9 - Reconfiguration flag sets when the receive line stays idle for 82 microseconds.
// RL10 - The clear-flags command clears the reconfiguration flag.
// RL11 - Interrupt while reconfiguration or transmitter available is high with its mask bit.
// RL12 - Software checks the self-caused reconfiguration flag after a reconfiguration interrupt.
// RL13 - Message acknowledged sets when the enabled transmission is acknowledged.
// RL14 - Software trusts message acknowledged only once transmitter available is set.
// RL15 - Broadcast packets never set message acknowledged.
// RL16 - A transmit-enable command clears message acknowledged.
// RL17 - Transmitter available sets after the last byte or on transmitter disable.
// RL18 - After transmit enable, transmitter available clears at the next token, not earlier.
// RL19 - Status reads 1XX1 0001 after hardware or software reset.
// RL20 - Commands reach the core as writes to the command register.
// RL21 - Reading status has no side effect on any flag.
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`default_nettype none
module token_bus_status_flags
    import flags_pkg::*;
#(
    parameter int unsigned IDLE_CYCLES_P = flags_pkg::IDLE_CYCLES
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [flags_pkg::ADDR_W-1:0] paddr,
    input wire logic [flags_pkg::DATA_W-1:0] pwdata,
    output logic [flags_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic receive_input,
    input wire logic soft_reset,
    input wire logic packet_stored,
    input wire logic packet_for_node,
    input wire logic token_received,
    input wire logic last_byte_sent,
    input wire logic tx_acked,
    input wire logic tx_broadcast,
    output logic receiver_inhibited,
    output logic nak_reply,
    output logic tx_request,
    output logic [flags_pkg::PAGE_W-1:0] rx_page,
    output logic [flags_pkg::PAGE_W-1:0] tx_page,
    output logic irq
);
    import flags_pkg::*;

    function automatic logic is_cmd(input logic [DATA_W-1:0] word, input logic [OPCODE_W-1:0] op);
        is_cmd = (word[OPCODE_LSB +: OPCODE_W] == op);
    endfunction

    function automatic logic is_addr(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
        is_addr = (a == r);
    endfunction

    reg_access_if bus ();

    apb_port u_apb_port
    (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .bus(bus)
    );

    // Software-visible state, plus the internal acknowledge and transmit sequencer state.
    logic reset_occurred;
    logic line_reconfigured;
    logic message_acknowledged;
    logic transmitter_available;
    logic [7:0] interrupt_mask_register;
    logic [7:0] node_id;
    logic awaiting_ack;
    tx_state_e tx_state;
    tx_state_e next_tx_state;

    // Receive line synchroniser.
    logic rx_meta;
    logic rx_sync;
    logic rx_prev;

    // Command and register write decode.
    wire cmd_wr = bus.wr_stb & is_addr(bus.addr, COMMAND_ADDR);
    wire mask_wr = bus.wr_stb & is_addr(bus.addr, MASK_ADDR);
    wire node_wr = bus.wr_stb & is_addr(bus.addr, NODE_ID_ADDR);
    wire cmd_rx_enable = cmd_wr & is_cmd(bus.wdata, CMD_RX_ENABLE);
    wire cmd_tx_enable = cmd_wr & is_cmd(bus.wdata, CMD_TX_ENABLE);
    wire cmd_tx_disable = cmd_wr & is_cmd(bus.wdata, CMD_TX_DISABLE);
    wire cmd_clear_flags = cmd_wr & is_cmd(bus.wdata, CMD_CLEAR_FLAGS);
    wire [PAGE_W-1:0] cmd_page = bus.wdata[PAGE_LSB +: PAGE_W];
    wire node_id_zeroed = node_wr & (bus.wdata[7:0] == NODE_ID_UNSET);

    // Flag events.
    wire packet_landed = packet_stored & ~receiver_inhibited;
    wire acked_event = tx_acked & awaiting_ack & ~tx_broadcast;
    wire token_take = token_received & (tx_state == TX_WAIT_TOKEN);
    wire send_done = last_byte_sent & (tx_state == TX_SENDING);
    wire idle_expired;
    wire rx_activity = rx_sync & ~rx_prev;

    // The line counts as busy while the synchronised input is high.
    line_idle_timer #(.CYCLES(IDLE_CYCLES_P)) u_line_idle_timer
    (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .activity(rx_activity | rx_sync),
        .expired(idle_expired)
    );

    // Status view; undefined bits 6 and 5 read as zero, test bit fixed low.
    wire [7:0] core_status = {receiver_inhibited, // see RL1
                              1'b0, 1'b0, // see RL5
                              reset_occurred,
                              1'b0, // see RL8
                              line_reconfigured,
                              message_acknowledged,
                              transmitter_available};

    // Reads only select data, so no flag changes on a read.
    assign bus.hit = is_addr(bus.addr, STATUS_ADDR) | is_addr(bus.addr, COMMAND_ADDR)
                   | is_addr(bus.addr, MASK_ADDR) | is_addr(bus.addr, NODE_ID_ADDR);
    assign bus.rdata = is_addr(bus.addr, STATUS_ADDR) ? DATA_W'(core_status) : // see RL21
                       is_addr(bus.addr, MASK_ADDR) ? DATA_W'(interrupt_mask_register) :
                       is_addr(bus.addr, NODE_ID_ADDR) ? DATA_W'(node_id) :
                       '0;

    // Each interrupt source is gated by its own mask bit.
    wire irq_level = (receiver_inhibited & interrupt_mask_register[RX_INHIB_BIT]) // see RL3
                   | (line_reconfigured & interrupt_mask_register[RECONF_BIT]) // see RL11
                   | (transmitter_available & interrupt_mask_register[TX_AVAIL_BIT]); // see RL11

    // The request output leaves a flip-flop that is loaded from the next state,
    // so it never shows a glitch of the state decode.
    wire next_tx_request = (next_tx_state == TX_WAIT_TOKEN);

    // Transmit sequencing; a disable command abandons a pending send.
    always_comb
    begin
        next_tx_state = tx_state;
        case (tx_state)
            TX_IDLE:
            begin
                if (cmd_tx_enable)
                begin
                    next_tx_state = TX_WAIT_TOKEN;
                end
            end
            TX_WAIT_TOKEN:
            begin
                if (cmd_tx_disable)
                begin
                    next_tx_state = TX_IDLE;
                end
                else if (token_received)
                begin
                    next_tx_state = TX_SENDING; // see RL18
                end
            end
            TX_SENDING:
            begin
                // The last byte or a disable command returns the sequencer to idle.
                if (cmd_tx_disable | last_byte_sent)
                begin
                    next_tx_state = TX_IDLE;
                end
            end
            default:
            begin
                next_tx_state = TX_IDLE;
            end
        endcase
    end

    // Two flip-flops bring the asynchronous line input into the clock domain.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_meta <= 1'b0;
            rx_sync <= 1'b0;
            rx_prev <= 1'b0;
        end
        else if (clk_en)
        begin
            rx_meta <= receive_input;
            rx_sync <= rx_meta;
            rx_prev <= rx_sync;
        end
    end

    // Software-written registers and the irq and nak_reply outputs; a read never reaches this process.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            interrupt_mask_register <= MASK_RESET;
            node_id <= NODE_ID_RESET;
            rx_page <= PAGE_RESET;
            tx_page <= PAGE_RESET;
            irq <= 1'b0;
            nak_reply <= 1'b0;
        end
        else if (clk_en)
        begin
            if (mask_wr)
            begin
                interrupt_mask_register <= bus.wdata[7:0];
            end
            if (node_wr)
            begin
                node_id <= bus.wdata[7:0];
            end
            if (cmd_rx_enable)
            begin
                rx_page <= cmd_page;
            end
            if (cmd_tx_enable)
            begin
                tx_page <= cmd_page;
            end
            irq <= irq_level;
            // A station that sends to us while the receiver is off gets a refusal.
            nak_reply <= packet_for_node & receiver_inhibited; // see RL4
        end
    end

    // Flags; a software reset wins over everything, otherwise a setting event wins over a clear in the same cycle.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            receiver_inhibited <= STATUS_RESET[RX_INHIB_BIT]; // see RL19
            reset_occurred <= STATUS_RESET[RESET_SEEN_BIT];
            line_reconfigured <= STATUS_RESET[RECONF_BIT];
            message_acknowledged <= STATUS_RESET[ACKED_BIT];
            transmitter_available <= STATUS_RESET[TX_AVAIL_BIT];
            awaiting_ack <= 1'b0;
            tx_state <= TX_IDLE;
            tx_request <= 1'b0;
        end
        else if (clk_en)
        begin
            if (soft_reset)
            begin
                // A software reset restores the reset pattern; mask, node id and pages stay.
                receiver_inhibited <= STATUS_RESET[RX_INHIB_BIT]; // see RL19
                reset_occurred <= STATUS_RESET[RESET_SEEN_BIT]; // see RL6
                line_reconfigured <= STATUS_RESET[RECONF_BIT];
                message_acknowledged <= STATUS_RESET[ACKED_BIT];
                transmitter_available <= STATUS_RESET[TX_AVAIL_BIT];
                awaiting_ack <= 1'b0;
                tx_state <= TX_IDLE;
                tx_request <= 1'b0;
            end
            else
            begin
                // A packet is only taken while the receiver is enabled.
                if (packet_landed)
                begin
                    receiver_inhibited <= 1'b1; // see RL1
                end
                else if (cmd_rx_enable)
                begin
                    receiver_inhibited <= 1'b0; // see RL2
                end

                // Writing a zero node id counts as a reset of the core.
                if (node_id_zeroed)
                begin
                    reset_occurred <= 1'b1; // see RL6
                end
                else if (cmd_clear_flags)
                begin
                    reset_occurred <= 1'b0; // see RL7
                end

                // The idle timer pulse marks a reconfiguration of the line.
                if (idle_expired)
                begin
                    line_reconfigured <= 1'b1; // see RL9
                end
                else if (cmd_clear_flags)
                begin
                    line_reconfigured <= 1'b0; // see RL10
                end

                if (acked_event)
                begin
                    message_acknowledged <= 1'b1; // see RL13 RL15
                end
                else if (cmd_tx_enable)
                begin
                    message_acknowledged <= 1'b0; // see RL16
                end

                // Availability drops when the token arrives, never on the enable itself.
                if (send_done | cmd_tx_disable)
                begin
                    transmitter_available <= 1'b1; // see RL17
                end
                else if (token_take)
                begin
                    transmitter_available <= 1'b0; // see RL18
                end

                // Acknowledges count only for the packet sent after the latest enable.
                if (token_take)
                begin
                    awaiting_ack <= 1'b1;
                end
                else if (cmd_tx_enable | cmd_tx_disable)
                begin
                    awaiting_ack <= 1'b0;
                end

                tx_state <= next_tx_state;
                tx_request <= next_tx_request;
            end
        end
    end
endmodule
`default_nettype wire

// [rtl/flags_pkg.sv]
// Shared constants and types for the token-bus status flag block.
`default_nettype none
package flags_pkg;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned PAGE_W = 2;
    localparam int unsigned IDLE_CNT_W = 16;

    // Register byte addresses.
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 12'h000;
    localparam logic [ADDR_W-1:0] COMMAND_ADDR = 12'h004;
    localparam logic [ADDR_W-1:0] MASK_ADDR = 12'h008;
    localparam logic [ADDR_W-1:0] NODE_ID_ADDR = 12'h00c;

    // Status bit positions.
    localparam int unsigned RX_INHIB_BIT = 7;
    localparam int unsigned RESET_SEEN_BIT = 4;
    localparam int unsigned TEST_BIT = 3;
    localparam int unsigned RECONF_BIT = 2;
    localparam int unsigned ACKED_BIT = 1;
    localparam int unsigned TX_AVAIL_BIT = 0;

    // Reset values; undefined status bits read as zero.
    localparam logic [7:0] STATUS_RESET = 8'h91;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] NODE_ID_RESET = 8'h00;
    localparam logic [7:0] NODE_ID_UNSET = 8'h00;
    localparam logic [PAGE_W-1:0] PAGE_RESET = 2'h0;

    // Command layout: opcode in the low nibble, buffer page above it.
    localparam int unsigned OPCODE_LSB = 0;
    localparam int unsigned OPCODE_W = 4;
    localparam int unsigned PAGE_LSB = 4;
    localparam logic [OPCODE_W-1:0] CMD_TX_DISABLE = 4'h1;
    localparam logic [OPCODE_W-1:0] CMD_TX_ENABLE = 4'h3;
    localparam logic [OPCODE_W-1:0] CMD_RX_ENABLE = 4'h4;
    localparam logic [OPCODE_W-1:0] CMD_CLEAR_FLAGS = 4'h6;

    // Line idle time.
    localparam int unsigned IDLE_TIME_NS = 82000;
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned IDLE_CYCLES = (IDLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [2:0]
    {
        TX_IDLE = 3'b001,
        TX_WAIT_TOKEN = 3'b010,
        TX_SENDING = 3'b100
    } tx_state_e;
endpackage
`default_nettype wire

// [rtl/reg_access_if.sv]
// Register access carrier between the bus port and the flag logic.
`default_nettype none
interface reg_access_if;
    import flags_pkg::*;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr_stb;
    logic [DATA_W-1:0] rdata;
    logic hit;

    modport port (output addr, output wdata, output wr_stb, input rdata, input hit);
    modport regs (input addr, input wdata, input wr_stb, output rdata, output hit);
endinterface
`default_nettype wire

// [rtl/apb_port.sv]
// APB slave port with no wait states and registered answers.
`default_nettype none
module apb_port
    import flags_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [flags_pkg::ADDR_W-1:0] paddr,
    input wire logic [flags_pkg::DATA_W-1:0] pwdata,
    output logic [flags_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    reg_access_if.port bus
);
    wire setup_phase = psel & ~penable;

    assign bus.addr = paddr;
    assign bus.wdata = pwdata;
    assign bus.wr_stb = clk_en & psel & penable & pwrite & pready & bus.hit;

    // The answer is prepared in the setup cycle and held for the access cycle.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else if (clk_en)
        begin
            pready <= setup_phase;
            pslverr <= setup_phase & ~bus.hit;
            if (setup_phase & ~pwrite)
            begin
                prdata <= bus.rdata;
            end
        end
    end
endmodule
`default_nettype wire

// [rtl/line_idle_timer.sv]
// Counts idle cycles on the receive line and pulses once per idle period.
`default_nettype none
module line_idle_timer
    import flags_pkg::*;
#(
    parameter int unsigned CYCLES = flags_pkg::IDLE_CYCLES
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic activity,
    output logic expired
);
    localparam logic [IDLE_CNT_W-1:0] LAST = IDLE_CNT_W'(CYCLES - 1);

    logic [IDLE_CNT_W-1:0] count;
    wire at_last = (count == LAST);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count <= '0;
            expired <= 1'b0;
        end
        else if (clk_en)
        begin
            expired <= ~activity & at_last;
            count <= (activity | at_last) ? '0 : count + 1'b1;
        end
    end
endmodule
`default_nettype wire

// [bench/cpu_model.sv]
// APB master that stands in for the on-chip processor.
`default_nettype none
module cpu_model
    import flags_pkg::*;
(
    input wire logic pclk,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [flags_pkg::DATA_W-1:0] prdata,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [flags_pkg::ADDR_W-1:0] paddr,
    output logic [flags_pkg::DATA_W-1:0] pwdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
    end
    // Every command reaches the core as a plain register write.
    task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
        output logic [DATA_W-1:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released lines show the inverse so stale values are never mistaken for data.
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule
`default_nettype wire

// [bench/status_sva.sv]
// Concurrent checks on the status flag block ports.
`default_nettype none
module status_sva
    import flags_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [flags_pkg::ADDR_W-1:0] paddr,
    input wire logic [flags_pkg::DATA_W-1:0] pwdata,
    input wire logic [flags_pkg::DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic packet_stored,
    input wire logic packet_for_node,
    input wire logic token_received,
    input wire logic receiver_inhibited,
    input wire logic nak_reply,
    input wire logic tx_request,
    input wire logic irq
);
    default clocking cb @(posedge pclk); endclocking
    // A frozen block changes nothing, so no check runs while the clock enable is low.
    default disable iff (!presetn || !clk_en);
    wire logic acc = clk_en && psel && penable && pready;
    wire logic cmd_wr = acc && pwrite && paddr == COMMAND_ADDR;
    wire logic rx_cmd = cmd_wr && pwdata[3:0] == CMD_RX_ENABLE;
    wire logic rd_stat = acc && !pwrite && paddr == STATUS_ADDR;
    logic [7:0] mask_q;
    // Shadow of the mask register, updated at the same access edge as the design.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mask_q <= MASK_RESET;
        else if (acc && pwrite && paddr == MASK_ADDR)
            mask_q <= pwdata[7:0];
    end
    a_nak_when_inhib: assert property (packet_for_node && receiver_inhibited |=> nak_reply)
        else $error("nak missing");
    a_nak_has_cause: assert property (nak_reply |-> $past(packet_for_node) && $past(receiver_inhibited))
        else $error("nak without cause");
    a_inhib_sets: assert property (packet_stored && !receiver_inhibited |=> receiver_inhibited)
        else $error("inhibit not set");
    a_inhib_holds: assert property (receiver_inhibited && !rx_cmd |=> receiver_inhibited)
        else $error("inhibit dropped");
    a_inhib_clears: assert property (rx_cmd && !packet_stored |=> !receiver_inhibited)
        else $error("inhibit not cleared");
    a_irq_rx_mask: assert property (receiver_inhibited && mask_q[7] |=> irq)
        else $error("irq missing");
    a_irq_masked_off: assert property (mask_q[7] == 1'b0 && mask_q[2] == 1'b0 && mask_q[0] == 1'b0 |=> !irq)
        else $error("irq while masked");
    a_status_read: assert property (rd_stat |-> prdata[7] == $past(receiver_inhibited)
        && prdata[6:5] == 2'b00 && prdata[3] == 1'b0)
        else $error("status read wrong");
    a_token_takes: assert property (token_received && tx_request |=> !tx_request)
        else $error("request kept after token");
    c_nak: cover property (nak_reply);
    c_irq: cover property (irq);
    c_token: cover property ($fell(tx_request));
    c_unmapped: cover property (pslverr);
endmodule
bind token_bus_status_flags status_sva status_sva_i (.pclk(pclk), .presetn(presetn),
    .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .packet_stored(packet_stored),
    .packet_for_node(packet_for_node), .token_received(token_received),
    .receiver_inhibited(receiver_inhibited), .nak_reply(nak_reply), .tx_request(tx_request),
    .irq(irq));
`default_nettype wire

// [bench/testbench.sv]
// Self-checking bench for the status flag block.
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import flags_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic rx_in = 1'b1;
    logic bcast = 1'b0;
    logic ce = 1'b1;
    logic [5:0] evs = 6'h00;
    logic psel, penable, pwrite, pready, pslverr, inh_o, nak, txr, irq, e, n;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [1:0] rxp, txp;
    logic inh = 1'b1, rst_f = 1'b1, idle_f = 1'b0, ack_f = 1'b0, avail_f = 1'b1;
    logic [31:0] seed = 32'ha08c;
    int num_errors = 0;
    int total_checks = 0;
    cpu_model cpu_model_i (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    token_bus_status_flags #(.IDLE_CYCLES_P(20)) token_bus_status_flags_i (.pclk(pclk),
        .presetn(presetn), .clk_en(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .receive_input(rx_in), .soft_reset(evs[0]), .packet_stored(evs[1]),
        .packet_for_node(evs[2]), .token_received(evs[3]), .last_byte_sent(evs[4]),
        .tx_acked(evs[5]), .tx_broadcast(bcast), .receiver_inhibited(inh_o), .nak_reply(nak),
        .tx_request(txr), .rx_page(rxp), .tx_page(txp), .irq(irq));
    initial
    begin
        forever #4 pclk = ~pclk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] st();
        return {inh, 2'b00, rst_f, 1'b0, idle_f, ack_f, avail_f};
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("errors %0d checks %0d", num_errors, total_checks);
        if (num_errors == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        cpu_model_i.xfer(1'b1, a, d, r, e);
    endtask
    task automatic cmd(input logic [3:0] op, input logic [1:0] pg);
        wr(COMMAND_ADDR, {26'h0, pg, op});
    endtask
    task automatic rs();
        cpu_model_i.xfer(1'b0, STATUS_ADDR, 32'h0, r, e);
        chk("status", r, {24'h0, st()});
        @(negedge pclk);
        chk("inhibited", 32'(inh_o), 32'(inh));
    endtask
    task automatic ev(input int k);
        @(posedge pclk);
        evs[k] <= 1'b1;
        @(posedge pclk);
        evs[k] <= 1'b0;
        @(negedge pclk);
        n = nak;
    endtask
    task automatic cyc(input int c);
        repeat (c) @(negedge pclk);
    endtask
    // The whole sequence needs well under two thousand cycles.
    initial
    begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        end_sim();
    end
    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rs();
        rs();
        ev(2);
        chk("nak", 32'(n), 32'h1);
        ev(1);
        rs();
        cmd(CMD_CLEAR_FLAGS, 2'h0);
        rst_f = 1'b0;
        rs();
        repeat (4)
        begin
            seed = lfsr(seed);
            cmd(CMD_RX_ENABLE, seed[1:0]);
            inh = 1'b0;
            cyc(1);
            chk("rx_page", 32'(rxp), 32'(seed[1:0]));
            rs();
            ev(2);
            chk("nak", 32'(n), 32'h0);
            @(posedge pclk);
            ce <= 1'b0;
            ev(1);
            @(posedge pclk);
            ce <= 1'b1;
            rs();
            ev(1);
            inh = 1'b1;
            rs();
            seed = lfsr(seed);
            wr(NODE_ID_ADDR, {24'h0, seed[7:1], 1'b1});
            rs();
        end
        wr(NODE_ID_ADDR, 32'h0);
        rst_f = 1'b1;
        rs();
        wr(STATUS_ADDR, 32'h0);
        rs();
        cpu_model_i.xfer(1'b0, 12'h010, 32'h0, r, e);
        chk("pslverr", 32'(e), 32'h1);
        wr(MASK_ADDR, 32'h80);
        cyc(2);
        chk("irq", 32'(irq), 32'h1);
        wr(MASK_ADDR, 32'h01);
        cyc(2);
        chk("irq", 32'(irq), 32'h1);
        wr(MASK_ADDR, 32'h04);
        cyc(2);
        chk("irq", 32'(irq), 32'h0);
        @(posedge pclk);
        rx_in <= 1'b0;
        cyc(8);
        rs();
        repeat (30) @(posedge pclk);
        rx_in <= 1'b1;
        idle_f = 1'b1;
        rs();
        cyc(2);
        chk("irq", 32'(irq), 32'h1);
        wr(MASK_ADDR, 32'h0);
        cmd(CMD_CLEAR_FLAGS, 2'h0);
        rst_f = 1'b0;
        idle_f = 1'b0;
        rs();
        for (int b = 0; b < 2; b++)
        begin
            @(posedge pclk);
            bcast <= b[0];
            seed = lfsr(seed);
            cmd(CMD_TX_ENABLE, seed[1:0]);
            ack_f = 1'b0;
            cyc(1);
            chk("tx_page", 32'(txp), 32'(seed[1:0]));
            chk("tx_request", 32'(txr), 32'h1);
            rs();
            ev(3);
            avail_f = 1'b0;
            chk("tx_request", 32'(txr), 32'h0);
            rs();
            ev(4);
            avail_f = 1'b1;
            rs();
            ev(5);
            ack_f = ~b[0];
            rs();
        end
        cmd(CMD_TX_ENABLE, 2'h0);
        ack_f = 1'b0;
        ev(3);
        avail_f = 1'b0;
        cmd(CMD_TX_DISABLE, 2'h0);
        avail_f = 1'b1;
        rs();
        ev(0);
        {inh, rst_f, idle_f, ack_f, avail_f} = 5'b11001;
        rs();
        end_sim();
    end
endmodule
`default_nettype wire
